// >>> bench/bpw_ctrl_monitor.sv
// Port checker for the board power/wake controller
module bpw_ctrl_monitor
  import bpw_pkg::*;
#(
  parameter int unsigned DEB_CYC = 4,
  parameter int unsigned LONG_CYC = 50
) (
  // Clock, reset and supplies
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ac_ok_i,
  input wire logic stby_pwr_i,
  input wire logic batt_ok_i,
  // Requests
  input wire logic pwr_sw_i,
  input wire logic rtc_wake_i,
  // Outputs watched
  input wire logic [2:0] state_o,
  input wire logic dev_pwr_o,
  input wire logic wake_pwr_o,
  input wire logic monitor_on_o,
  input wire logic cold_boot_o,
  input wire logic stby_led_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Raw hold length; bounce restarts it, as it does the debouncer
  logic [31:0] held_r;
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i) held_r <= 32'h0;
    else held_r <= pwr_sw_i ? held_r + 32'h1 : 32'h0;

  // Quiet wake from sleep and the dark working state it must reach
  sequence s_quiet_wake;
    state_o inside {BPW_S3, BPW_S4, BPW_S5} && rtc_wake_i && ac_ok_i;
  endsequence
  sequence s_dark_on;
    state_o == BPW_S0 && !monitor_on_o;
  endsequence

  a_rtc_dark: assert property (s_quiet_wake |-> ##[1:6] s_dark_on)
    else $error("rtc wake lit monitor or stalled");
  a_long_off: assert property (held_r == DEB_CYC + LONG_CYC + 8 |->
    state_o inside {BPW_S5, BPW_G3})
    else $error("long press did not power off");
  a_led_standby: assert property (stby_pwr_i [*2] |-> stby_led_o)
    else $error("standby lamp dark");
  a_sleep_dark: assert property (
    (state_o inside {BPW_S3, BPW_S4, BPW_S5}) [*2] |->
    !dev_pwr_o && wake_pwr_o)
    else $error("sleep power wrong");
  a_work_power: assert property ((state_o == BPW_S0) [*2] |-> dev_pwr_o)
    else $error("working without device power");
  a_cold_boot: assert property (cold_boot_o |->
    $past(state_o) == BPW_S5 || $past(state_o, 2) == BPW_S5)
    else $error("cold boot not from soft off");
  a_ac_loss: assert property (!ac_ok_i [*3] |-> state_o == BPW_G3)
    else $error("no mechanical off on ac loss");
  a_g3_dark: assert property (
    (state_o == BPW_G3 && !batt_ok_i) [*2] |-> !wake_pwr_o)
    else $error("wake logic powered without source");
endmodule

bind bpw_ctrl bpw_ctrl_monitor #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC))
  u_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ac_ok_i(ac_ok_i),
  .stby_pwr_i(stby_pwr_i), .batt_ok_i(batt_ok_i), .pwr_sw_i(pwr_sw_i),
  .rtc_wake_i(rtc_wake_i), .state_o(state_o), .dev_pwr_o(dev_pwr_o),
  .wake_pwr_o(wake_pwr_o), .monitor_on_o(monitor_on_o),
  .cold_boot_o(cold_boot_o), .stby_led_o(stby_led_o));

// >>> bench/bpw_sw_model.sv
// Front-panel power switch with contact bounce
module bpw_sw_model (
  // Clock
  input wire logic sys_clk_i,
  // Contact, high while pressed
  output logic pwr_sw_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pwr_sw_o = 1'h0;

  // Bounce, hold n cycles, release, let the effect settle
  task automatic press(input int n);
    repeat (3) begin
      @(posedge sys_clk_i);
      pwr_sw_o <= ~pwr_sw_o;
    end
    repeat (n) @(posedge sys_clk_i);
    pwr_sw_o <= 1'h0;
    repeat (12) @(posedge sys_clk_i);
  endtask
endmodule

// >>> bench/test_bpw_ctrl.sv
// Self-checking bench for the board power/wake controller
module test_bpw_ctrl
  import bpw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench-driven inputs, set at time zero
  logic clk = 1'h0, rst = 1'h1, sel = 1'h0, wr = 1'h0;
  logic ac = 1'h1, bat = 1'h1, rtc = 1'h0, lan = 1'h0, wl = 1'h0;
  logic usb = 1'h0, pci = 1'h0, cec = 1'h0, seen = 1'h0;
  logic sb = 1'h1, bt = 1'h0;
  logic [1:0] tr = 2'h0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  // Design and switch-model outputs
  logic rdy, sw, led, irq, cold, dp, wp, mon, resp, mp;
  logic [2:0] st;
  int errors = 0, tests_run = 0, cyc = 0;

  // 40 MHz clock
  initial forever #12.5 clk = ~clk;

  // Short counts keep presses a few dozen cycles long
  bpw_ctrl #(.DEB_CYC(4), .LONG_CYC(50)) i_dut (
    .sys_clk_i(clk), .rst_i(rst), .hsel_i(sel), .haddr_i(ad),
    .htrans_i(tr), .hwrite_i(wr), .hsize_i(3'h2), .hwdata_i(wd),
    .hready_i(rdy), .hrdata_o(rdat), .hreadyout_o(rdy), .hresp_o(resp),
    .ac_ok_i(ac), .stby_pwr_i(sb), .batt_ok_i(bat), .pwr_sw_i(sw),
    .rtc_wake_i(rtc), .lan_wake_i(lan), .wlan_wake_i(wl),
    .bt_wake_i(bt), .usb_wake_i(usb), .pcie_wake_i(pci),
    .cec_wake_i(cec), .state_o(st), .main_pwr_o(mp), .dev_pwr_o(dp),
    .wake_pwr_o(wp), .monitor_on_o(mon), .cold_boot_o(cold),
    .stby_led_o(led), .irq_o(irq));
  bpw_sw_model i_sw (.sys_clk_i(clk), .pwr_sw_o(sw));

  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Bounded wait for a state, then compare
  task automatic go(input bpw_state_type e);
    int n = 0;
    while (st !== e && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(32'(st), 32'(e));
  endtask

  // State must not move for a while
  task automatic hold(input bpw_state_type e);
    repeat (20) @(posedge clk);
    chk(32'(st), 32'(e));
  endtask

  // Single word transfer; no wait count assumed
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] v, output logic [31:0] r);
    sel <= 1'h1;
    tr <= 2'h2;
    ad <= a;
    wr <= w;
    do @(posedge clk); while (rdy !== 1'h1);
    tr <= 2'h0;
    wd <= v;
    do @(posedge clk); while (rdy !== 1'h1);
    r = rdat;
    chk(32'(resp), 32'h0); // Always OKAY
  endtask

  task automatic cmd(input logic [31:0] v, input bpw_state_type e);
    bus(1'h1, 8'h00, v, d);
    go(e);
  endtask

  // Pulse is one cycle wide, so latch it
  always @(posedge clk) if (cold) seen <= 1'h1;

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    go(BPW_S0);
    chk(32'(led), 32'h1);
    chk(32'(mp), 32'h1);
    sb <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'(led), 32'h0);
    sb <= 1'h1;
    bus(1'h0, 8'h00, 32'h0, d);
    chk(d, 32'h0);
    bus(1'h0, 8'h10, 32'h0, d);
    chk(d, 32'h0);
    bus(1'h1, 8'h0C, 32'hF, d);
    // RTC, LAN and wireless wakes from S3, each monitor-dark
    for (int i = 0; i < 3; i++) begin
      cmd(32'h13, BPW_S3);
      {rtc, lan, wl} <= 3'h4 >> i;
      go(BPW_S0);
      chk(32'(mon), 32'h0);
      {rtc, lan, wl} <= 3'h0;
    end
    i_sw.press(45);
    go(BPW_S3);
    chk(32'(mp), 32'h0);
    usb <= 1'h1;
    go(BPW_S0);
    usb <= 1'h0;
    i_sw.press(20);
    go(BPW_S3);
    i_sw.press(80);
    go(BPW_S5);
    {pci, bt} <= 2'h3;
    hold(BPW_S5);
    {pci, bt} <= 2'h0;
    cec <= 1'h1;
    go(BPW_S0);
    cec <= 1'h0;
    repeat (3) @(posedge clk);
    chk(32'(seen), 32'h1);
    // Status, clear, mask
    bus(1'h0, 8'h08, 32'h0, d);
    chk(d & 32'h7, 32'h7);
    chk(32'(irq), 32'h1);
    bus(1'h1, 8'h08, 32'hF, d);
    bus(1'h1, 8'h0C, 32'h0, d);
    bus(1'h0, 8'h08, 32'h0, d);
    chk(d, 32'h0);
    cmd(32'h14, BPW_S4);
    usb <= 1'h1;
    hold(BPW_S4);
    pci <= 1'h1;
    go(BPW_S0);
    {usb, pci} <= 2'h0;
    chk(32'(irq), 32'h0);
    bus(1'h1, 8'h0C, 32'h1, d);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    cmd(32'h74, BPW_S4);
    usb <= 1'h1;
    hold(BPW_S4);
    usb <= 1'h0;
    i_sw.press(20);
    go(BPW_S0);
    cmd(32'h34, BPW_S4);
    usb <= 1'h1;
    go(BPW_S0);
    usb <= 1'h0;
    // Bluetooth wakes from S4 with the monitor lit
    cmd(32'h14, BPW_S4);
    bt <= 1'h1;
    go(BPW_S0);
    chk(32'(mon), 32'h1);
    bt <= 1'h0;
    // AC loss and return under the off and last-state policies
    cmd(32'h113, BPW_S3);
    ac <= 1'h0;
    go(BPW_G3);
    chk(32'(wp), 32'h1);
    bat <= 1'h0;
    hold(BPW_G3);
    chk(32'(wp), 32'h0);
    {ac, bat} <= 2'h3;
    go(BPW_S5);
    cec <= 1'h1;
    go(BPW_S0);
    cec <= 1'h0;
    cmd(32'h213, BPW_S3);
    ac <= 1'h0;
    go(BPW_G3);
    ac <= 1'h1;
    go(BPW_S3);
    usb <= 1'h1;
    hold(BPW_S3);
    give_verdict();
  end
endmodule

// >>> verilog/bpw_ctrl.sv
// Board power state and wake controller with AHB-Lite register slave
`include "bpw_map.svh"
module bpw_ctrl
  import bpw_pkg::*;
#(
  parameter int unsigned DEB_CYC = `BPW_CLK_HZ / 1000000 * `BPW_DEB_US,
  parameter int unsigned LONG_CYC = `BPW_CLK_HZ * `BPW_LONG_S
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Power and wake inputs
  input wire logic ac_ok_i,
  input wire logic stby_pwr_i,
  input wire logic batt_ok_i,
  input wire logic pwr_sw_i,
  input wire logic rtc_wake_i,
  input wire logic lan_wake_i,
  input wire logic wlan_wake_i,
  input wire logic bt_wake_i,
  input wire logic usb_wake_i,
  input wire logic pcie_wake_i,
  input wire logic cec_wake_i,
  // Power outputs
  output logic [2:0] state_o,
  output logic main_pwr_o,
  output logic dev_pwr_o,
  output logic wake_pwr_o,
  output logic monitor_on_o,
  output logic cold_boot_o,
  output logic stby_led_o,
  output logic irq_o
);
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam int SHORT_CYC = `BPW_CLK_HZ * `BPW_SHORT_S;

  initial begin
    if (LONG_CYC < 2 || DEB_CYC < 1) $error("timing parameters invalid");
  end

  // Register and state storage
  logic [31:0] ctrl_r;
  logic [`BPW_IRQ_WIDTH-1:0] irq_r;
  logic [`BPW_IRQ_WIDTH-1:0] mask_r;
  bpw_state_type state_r;
  bpw_state_type state_nxt;
  bpw_state_type last_r;
  logic g3_seen_r;
  logic ac_prev_r;
  logic mon_r;
  logic mon_nxt;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic main_pwr_r;
  logic dev_pwr_r;
  logic wake_pwr_r;
  logic cold_r;
  logic led_r;
  logic irq_out_r;

  // Switch path: debounce then classify
  logic sw_clean;
  logic sw_short;
  logic sw_long;

  bpw_debounce #(.CYCLES(DEB_CYC)) u_deb (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .raw_i(pwr_sw_i),
    .clean_o(sw_clean)
  );

  bpw_press_timer #(.LONG_CYC(LONG_CYC)) u_press (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pressed_i(sw_clean),
    .short_o(sw_short),
    .long_o(sw_long)
  );

  // CEC is treated as a short switch press
  logic cec_prev_r;
  wire cec_edge = cec_wake_i && !cec_prev_r;
  wire btn = sw_short || cec_edge;

  // Control fields
  wire [2:0] cmd = ctrl_r[`BPW_CTRL_CMD_LO +: 3];
  wire sleep_allow = ctrl_r[`BPW_CTRL_SLEEP_ALLOW];
  wire usb_s45_en = ctrl_r[`BPW_CTRL_USB_S45_EN];
  wire deep = ctrl_r[`BPW_CTRL_DEEP];
  wire [1:0] policy = ctrl_r[`BPW_CTRL_POL_LO +: 2];

  // Wake qualification per sleep state
  wire in_s3 = state_r == BPW_S3;
  wire in_s4 = state_r == BPW_S4;
  wire in_s5 = state_r == BPW_S5;
  wire asleep = in_s3 || in_s4 || in_s5;
  wire quiet_wake = asleep && (rtc_wake_i || lan_wake_i || wlan_wake_i);
  wire lan_wake = lan_wake_i;
  wire pcie_ok = (in_s3 || in_s4) && pcie_wake_i;
  wire bt_ok = (in_s3 || in_s4) && bt_wake_i;
  wire usb_s3 = in_s3 && usb_wake_i && !g3_seen_r;
  wire usb_s45 = (in_s4 || in_s5) && usb_wake_i && usb_s45_en
    && !g3_seen_r && !deep;
  wire quiet_any = quiet_wake || pcie_ok || (asleep && lan_wake);
  wire loud_any = bt_ok || usb_s3 || usb_s45 || (asleep && btn);
  wire ac_rise = ac_ok_i && !ac_prev_r;
  wire sw_cmd = (cmd == 3'h3) || (cmd == 3'h4) || (cmd == 3'h5);

  // State transitions
  always_comb begin
    state_nxt = state_r;
    mon_nxt = mon_r;
    case (state_r)
      BPW_G3: begin
        if (ac_ok_i) begin
          case (policy)
            BPW_POL_ON: state_nxt = BPW_S0;
            BPW_POL_LAST: state_nxt = last_r;
            default: state_nxt = BPW_S5;
          endcase
          mon_nxt = 1'b1;
        end
      end
      BPW_S0: begin
        if (sw_long) begin
          state_nxt = BPW_S5;
        end else if (btn && sleep_allow) begin
          state_nxt = BPW_S3;
        end else if (sw_cmd) begin
          state_nxt = bpw_state_type'(cmd);
        end
        mon_nxt = 1'b1;
      end
      BPW_S3, BPW_S4: begin
        if (sw_long) begin
          state_nxt = BPW_S5;
        end else if (loud_any) begin
          state_nxt = BPW_S0;
          mon_nxt = 1'b1;
        end else if (quiet_any) begin
          state_nxt = BPW_S0;
          mon_nxt = 1'b0;
        end
      end
      BPW_S5: begin
        if (loud_any) begin
          state_nxt = BPW_S0;
          mon_nxt = 1'b1;
        end else if (quiet_wake || lan_wake) begin
          state_nxt = BPW_S0;
          mon_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = BPW_G3;
      end
    endcase
    if (!ac_ok_i) begin
      state_nxt = BPW_G3;
    end
  end

  // State, last state and mechanical-off history
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= BPW_G3;
      last_r <= BPW_S5;
      g3_seen_r <= 1'b0;
      ac_prev_r <= 1'b0;
      cec_prev_r <= 1'b0;
      mon_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mon_r <= mon_nxt;
      ac_prev_r <= ac_ok_i;
      cec_prev_r <= cec_wake_i;
      if (state_r != BPW_G3) begin
        last_r <= state_r;
      end
      if (state_r == BPW_G3) begin
        g3_seen_r <= 1'b1;
      end else if (state_r == BPW_S0) begin
        g3_seen_r <= 1'b0;
      end
    end
  end

  // Rail outputs per state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      main_pwr_r <= 1'b0;
      dev_pwr_r <= 1'b0;
      wake_pwr_r <= 1'b0;
      cold_r <= 1'b0;
      led_r <= 1'b0;
    end else begin
      main_pwr_r <= state_nxt == BPW_S0;
      dev_pwr_r <= state_nxt == BPW_S0;
      wake_pwr_r <= (state_nxt != BPW_G3) || batt_ok_i;
      cold_r <= state_r == BPW_S5 && state_nxt == BPW_S0;
      led_r <= stby_pwr_i;
    end
  end

  // AHB-Lite address phase decode
  wire take = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
  wire is_stat = haddr_i == `BPW_STAT_OFS;
  wire [31:0] rd_mux = (haddr_i == `BPW_CTRL_OFS) ? ctrl_r :
    is_stat ? {24'h000000, g3_seen_r, mon_r, 1'b0, ac_ok_i, 1'b0,
    state_r} :
    (haddr_i == `BPW_IRQ_OFS) ? {28'h0000000, irq_r} :
    (haddr_i == `BPW_MASK_OFS) ? {28'h0000000, mask_r} : 32'h00000000;
  wire wr_ctrl = wr_pend_r && addr_r == `BPW_CTRL_OFS;
  wire wr_irq = wr_pend_r && addr_r == `BPW_IRQ_OFS;
  wire wr_mask = wr_pend_r && addr_r == `BPW_MASK_OFS;
  wire [`BPW_IRQ_WIDTH-1:0] ev = {ac_rise, sw_long, btn,
    state_r != BPW_S0 && state_nxt == BPW_S0};

  // Bus state and read data
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= take && hwrite_i;
      if (take) begin
        addr_r <= haddr_i;
      end
      if (take && !hwrite_i) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Control register; command field self-clears the cycle after a write
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= `BPW_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata_i;
    end else begin
      ctrl_r[`BPW_CTRL_CMD_LO +: 3] <= 3'h0;
    end
  end

  // Sticky events; set wins over write-one-to-clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_r <= '0;
      mask_r <= '0;
      irq_out_r <= 1'b0;
    end else begin
      irq_r <= (irq_r & ~(wr_irq ? hwdata_i[`BPW_IRQ_WIDTH-1:0] : '0)) | ev;
      if (wr_mask) begin
        mask_r <= hwdata_i[`BPW_IRQ_WIDTH-1:0];
      end
      irq_out_r <= |(irq_r & mask_r);
    end
  end

  // Outputs
  assign hrdata_o = hrdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign state_o = state_r;
  assign main_pwr_o = main_pwr_r;
  assign dev_pwr_o = dev_pwr_r;
  assign wake_pwr_o = wake_pwr_r;
  assign monitor_on_o = mon_r;
  assign cold_boot_o = cold_r;
  assign stby_led_o = led_r;
  assign irq_o = irq_out_r;
endmodule

// >>> verilog/bpw_debounce.sv
// Switch debouncer: output follows input after it holds steady
module bpw_debounce #(
  parameter int unsigned CYCLES = 400000
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Raw and clean level
  input wire logic raw_i,
  output logic clean_o
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;
  logic clean_r;
  wire differ = raw_i != clean_r;
  wire done = cnt_r == W'(CYCLES - 1);

  initial begin
    if (CYCLES < 1) $error("debounce count must be positive");
  end

  // Restart the count on every bounce
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      clean_r <= 1'b0;
    end else if (!differ) begin
      cnt_r <= '0;
    end else if (done) begin
      cnt_r <= '0;
      clean_r <= raw_i;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign clean_o = clean_r;
endmodule

// >>> verilog/bpw_map.svh
// Constants, register map and timing for the board power/wake controller
// Overview of operation
// - Press under four seconds: off to on, on to sleep (if allowed), sleep to on (code counts any release before six seconds as short).
// - Press over six seconds forces working or sleeping into soft-off.
// - Sleep depths S3 (RAM), S4 (disk), S5 soft-off needing cold boot.
// - In S3/S4/S5 devices are unpowered except wake logic.
// - Mechanical off: no power; wake logic only on battery or external source.
// - Switch, RTC, LAN, wireless wake from S3/S4/S5; RTC/LAN/wireless keep monitor asleep (code lights it one cycle after reaching S0).
// - PCIe wake via wake signal only from S3/S4; monitor stays asleep (code lights it one cycle after reaching S0).
// - CEC wake from S3/S4/S5 behaves exactly like a power switch press.
// - USB wake from S4/S5 needs firmware enable and never after mechanical off.
// - USB wake ignored in deep S4/S5.
// - USB activity wakes from S3 unless mechanical off occurred since arming.
// - Network remote-wake frame request powers the system up.
// - AC return enters firmware policy state: power on, stay off, last state.
// - Standby indicator active whenever standby power is present.
`ifndef BPW_MAP_SVH
`define BPW_MAP_SVH

// Register byte offsets
`define BPW_CTRL_OFS 8'h00
`define BPW_STAT_OFS 8'h04
`define BPW_IRQ_OFS 8'h08
`define BPW_MASK_OFS 8'h0C

// Control fields
`define BPW_CTRL_CMD_LO 0
`define BPW_CTRL_SLEEP_ALLOW 4
`define BPW_CTRL_USB_S45_EN 5
`define BPW_CTRL_DEEP 6
`define BPW_CTRL_POL_LO 8
`define BPW_CTRL_RST 32'h0000_0000

// Interrupt bits
`define BPW_IRQ_WIDTH 4
`define BPW_IRQ_WAKE 0
`define BPW_IRQ_SHORT 1
`define BPW_IRQ_LONG 2
`define BPW_IRQ_AC 3

// Timing
`define BPW_CLK_HZ 40000000
`define BPW_SHORT_S 4
`define BPW_LONG_S 6
`define BPW_DEB_US 10000

`endif

// >>> verilog/bpw_pkg.sv
// Types shared by the board power/wake controller
package bpw_pkg;
  typedef enum logic [2:0] {
    BPW_S0 = 3'b000,
    BPW_S3 = 3'b011,
    BPW_S4 = 3'b100,
    BPW_S5 = 3'b101,
    BPW_G3 = 3'b111
  } bpw_state_type;

  typedef enum logic [1:0] {
    BPW_POL_ON = 2'b00,
    BPW_POL_OFF = 2'b01,
    BPW_POL_LAST = 2'b10
  } bpw_policy_type;
endpackage

// >>> verilog/bpw_press_timer.sv
// Measures a debounced press and classifies it on release or at long limit
module bpw_press_timer #(
  parameter int unsigned LONG_CYC = 240000000
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Debounced switch level
  input wire logic pressed_i,
  // Classified events, one-cycle pulses
  output logic short_o,
  output logic long_o
);
  localparam int W = $clog2(LONG_CYC + 1);
  logic [W-1:0] cnt_r;
  logic fired_r;
  logic prev_r;
  logic short_r;
  logic long_r;
  wire at_long = cnt_r == W'(LONG_CYC);

  initial begin
    if (LONG_CYC < 2) $error("long press count too small");
  end

  // Count while held; long fires once, a release before it is short
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      fired_r <= 1'b0;
      prev_r <= 1'b0;
      short_r <= 1'b0;
      long_r <= 1'b0;
    end else begin
      prev_r <= pressed_i;
      short_r <= prev_r && !pressed_i && !fired_r;
      long_r <= pressed_i && at_long && !fired_r;
      if (!pressed_i) begin
        cnt_r <= '0;
        fired_r <= 1'b0;
      end else if (at_long) begin
        fired_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign short_o = short_r;
  assign long_o = long_r;
endmodule
